// File: rlc_host.sv
// Purpose: Controller that drives relay latch request lines, ordered over APB
// Assumes: One clock pclk; trip and stop pins are asynchronous
// Notes:   Sequencing times are parameters so a bench can shorten them
// Notes on behaviour
// - To close, the controller drives the open line low first and then the close line high.
// - To open, the controller drives the close line low first and then the open line high.
// - The open routine holds open high at least 3000 us, drops it, then waits another 3000 us.
// - The close routine drives close low, waits at least 3000 us, then drives it high.
// - Initialisation clears the stored stop value and the closed and opened flags only.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rlc_host
  import rlc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ground_fault_trip,
  input  wire logic        emergency_stop_input,
  output logic             relay_close_req,
  output logic             relay_close_req_oe_n,
  output logic             relay_open_req,
  output logic             relay_open_req_oe_n,
  output logic             irq
);
  logic             fault_s1_reg, fault_s2_reg, stop_s1_reg, stop_s2_reg;
  logic             fault_d_reg, stop_d_reg;
  rlc_state_t       st_reg, st_next;
  logic [31:0]      cnt_reg, cnt_next;
  logic             close_reg, close_next, open_reg, open_next, drive_reg, drive_next, oe_n_reg;
  logic             closed_flag_reg, closed_flag_next, opened_flag_reg, opened_flag_next;
  logic             estop_val_reg, estop_val_next;
  logic [2:0]       istat_reg, istat_next, imask_reg, imask_next;
  logic [31:0]      prdata_next;
  logic             pslverr_next, irq_next;
  logic             wr, rd, busy;

  // Pins from the board are asynchronous; only the second stage and its one-cycle delayed copy are read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_s1_reg <= 1'b0;
      fault_s2_reg <= 1'b0;
      stop_s1_reg  <= 1'b0;
      stop_s2_reg  <= 1'b0;
      fault_d_reg  <= 1'b0;
      stop_d_reg   <= 1'b0;
    end else begin
      fault_s1_reg <= ground_fault_trip;
      fault_s2_reg <= fault_s1_reg;
      stop_s1_reg  <= emergency_stop_input;
      stop_s2_reg  <= stop_s1_reg;
      fault_d_reg  <= fault_s2_reg;
      stop_d_reg   <= stop_s2_reg;
    end
  end

  assign wr   = psel && penable && pwrite;
  assign rd   = psel && !penable && !pwrite;
  assign busy = (st_reg != RLC_IDLE);

  always_comb begin
    st_next          = st_reg;
    cnt_next         = cnt_reg;
    close_next       = close_reg;
    open_next        = open_reg;
    drive_next       = drive_reg;
    closed_flag_next = closed_flag_reg;
    opened_flag_next = opened_flag_reg;
    estop_val_next   = estop_val_reg;
    istat_next       = istat_reg;
    imask_next       = imask_reg;
    // W1C first so events further down win a same-cycle clear
    if (wr && paddr == OFF_IRQ_STAT) begin
      istat_next = istat_next & ~pwdata[2:0];
    end
    case (st_reg)
      RLC_IDLE: begin
        if (wr && paddr == OFF_CTRL) begin
          if (pwdata[CTRL_INIT_BIT]) begin
            estop_val_next   = 1'b0;
            closed_flag_next = 1'b0;
            opened_flag_next = 1'b0;
          end else if (pwdata[CTRL_OPEN_BIT]) begin
            drive_next = 1'b1;
            // Open rises a cycle later so the latch sees close low first
            close_next = 1'b0;
            cnt_next   = HOLD_CYC;
            st_next    = RLC_OPEN_HI;
          end else if (pwdata[CTRL_CLOSE_BIT]) begin
            drive_next = 1'b1;
            open_next  = 1'b0;
            close_next = 1'b0;
            cnt_next   = HOLD_CYC;
            st_next    = RLC_CLOSE_LO;
          end
        end
      end
      RLC_OPEN_HI: begin
        if (!open_reg) begin
          open_next = 1'b1;
        end else if (cnt_reg <= 32'h0000_0001) begin
          open_next = 1'b0;
          cnt_next  = HOLD_CYC;
          st_next   = RLC_OPEN_LO;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      RLC_OPEN_LO: begin
        if (cnt_reg <= 32'h0000_0001) begin
          closed_flag_next = 1'b0;
          opened_flag_next = 1'b1;
          istat_next[EV_DONE_BIT] = 1'b1;
          st_next = RLC_IDLE;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      RLC_CLOSE_LO: begin
        if (cnt_reg <= 32'h0000_0001) begin
          close_next       = 1'b1;
          closed_flag_next = 1'b1;
          opened_flag_next = 1'b0;
          istat_next[EV_DONE_BIT] = 1'b1;
          st_next = RLC_IDLE;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      default: st_next = RLC_IDLE;
    endcase
    // A close request is dropped by the latch on faults; flag it
    if (fault_s2_reg && closed_flag_reg) begin
      closed_flag_next = 1'b0;
    end
    if (wr && paddr == OFF_IRQ_MASK) begin
      imask_next = pwdata[2:0];
    end
    // Set wins over a same-cycle clear
    if (fault_s2_reg && !fault_d_reg) begin
      istat_next[EV_FAULT_BIT] = 1'b1;
    end
    if (stop_s2_reg && !stop_d_reg) begin
      istat_next[EV_ESTOP_BIT] = 1'b1;
    end
    // Stored stop outranks an init in the same cycle
    if (stop_s2_reg) begin
      estop_val_next = 1'b1;
    end
  end

  always_comb begin
    prdata_next  = DATA_ZERO;
    pslverr_next = 1'b0;
    if (rd) begin
      case (paddr)
        OFF_CTRL:     prdata_next = {31'h0, busy};
        OFF_STATUS:   prdata_next = {26'h0, fault_s2_reg, stop_s2_reg, estop_val_reg,
                                     opened_flag_reg, closed_flag_reg, busy};
        OFF_IRQ_STAT: prdata_next = {29'h0, istat_reg};
        OFF_IRQ_MASK: prdata_next = {29'h0, imask_reg};
        default:      pslverr_next = 1'b1;
      endcase
    end else if (psel && !penable && pwrite) begin
      pslverr_next = !(paddr == OFF_CTRL || paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK);
    end
    irq_next = |(istat_next & imask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= RLC_IDLE;
      cnt_reg         <= DATA_ZERO;
      close_reg       <= 1'b0;
      open_reg        <= 1'b0;
      drive_reg       <= 1'b0; // Lines float until the first open or close command
      oe_n_reg        <= 1'b1;
      closed_flag_reg <= 1'b0;
      opened_flag_reg <= 1'b0;
      estop_val_reg   <= 1'b0;
      istat_reg       <= IRQ_RESET;
      imask_reg       <= IRQ_RESET;
      prdata          <= DATA_ZERO;
      pslverr         <= 1'b0;
      pready          <= 1'b0;
      irq             <= 1'b0;
    end else begin
      st_reg          <= st_next;
      cnt_reg         <= cnt_next;
      close_reg       <= close_next;
      open_reg        <= open_next;
      drive_reg       <= drive_next;
      oe_n_reg        <= !drive_next;
      closed_flag_reg <= closed_flag_next;
      opened_flag_reg <= opened_flag_next;
      estop_val_reg   <= estop_val_next;
      istat_reg       <= istat_next;
      imask_reg       <= imask_next;
      prdata          <= prdata_next;
      pslverr         <= pslverr_next;
      pready          <= psel && !penable;
      irq             <= irq_next;
    end
  end

  assign relay_close_req      = close_reg;
  assign relay_open_req       = open_reg;
  assign relay_close_req_oe_n = oe_n_reg;
  assign relay_open_req_oe_n  = oe_n_reg;
endmodule // rlc_host
`default_nettype wire

// File: rlc_pkg.sv
// Purpose: Constants for the relay latch controller (host side)
// Assumes: pclk at 125 MHz
// Notes:   Register offsets are byte addresses on APB
package rlc_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned HOLD_US        = 3000;
  localparam int unsigned HOLD_CYCLES    = HOLD_US * CLK_MHZ;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;
  localparam int unsigned CTRL_OPEN_BIT  = 0;
  localparam int unsigned CTRL_CLOSE_BIT = 1;
  localparam int unsigned CTRL_INIT_BIT  = 2;
  localparam int unsigned EV_DONE_BIT    = 0;
  localparam int unsigned EV_FAULT_BIT   = 1;
  localparam int unsigned EV_ESTOP_BIT   = 2;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;
  localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;
  typedef enum logic [2:0] {RLC_IDLE, RLC_OPEN_HI, RLC_OPEN_LO, RLC_CLOSE_LO, RLC_CLOSE_HI} rlc_state_t;
endpackage

// File: rlc_properties.sv
// Purpose: Request line ordering checks for rlc_host
// Assumes: Bound onto rlc_host
// Notes:   Counters replace long repetitions
`timescale 1ns/1ns
`default_nettype none
module rlc_properties
  import rlc_pkg::*;
#(parameter int unsigned HOLD_CYC = HOLD_CYCLES) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        relay_close_req,
  input wire logic        relay_close_req_oe_n,
  input wire logic        relay_open_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] hi_cnt, lo_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 32'h0;
      lo_cnt <= 32'h0;
    end else begin
      hi_cnt <= relay_open_req ? hi_cnt + 1 : 32'h0;
      lo_cnt <= (relay_close_req || relay_close_req_oe_n) ? 32'h0 : lo_cnt + 1;
    end
  end
  sequence init_wr;
    pready && pwrite && paddr == OFF_CTRL && pwdata[CTRL_INIT_BIT];
  endsequence
  a_close_order: assert property ($rose(relay_close_req) |-> !relay_open_req)
    else $error("close rose with open high");
  a_open_order: assert property ($rose(relay_open_req) |-> $past(!relay_close_req))
    else $error("open rose before close was low");
  a_open_hold: assert property ($fell(relay_open_req) |-> hi_cnt >= HOLD_CYC)
    else $error("open pulse too short");
  a_open_settle: assert property ($fell(relay_open_req) |=> !relay_close_req [*8])
    else $error("close raised during open settle");
  a_close_wait: assert property ($rose(relay_close_req) |-> lo_cnt >= HOLD_CYC)
    else $error("close low phase too short");
  a_init_quiet: assert property (init_wr |=> $stable(relay_close_req) && $stable(relay_open_req))
    else $error("init moved a request line");
endmodule // rlc_properties
`default_nettype wire

// File: rlc_latch_model.sv
// Purpose: Behavioural relay latch on the request lines
// Assumes: Undriven close line pulls the latch into reset
// Notes:   Clearing beats setting, as a real reset pin would
`timescale 1ns/1ns
`default_nettype none
module rlc_latch_model (
  input  wire logic close_line,
  input  wire logic close_oe_n,
  input  wire logic open_line,
  input  wire logic open_oe_n,
  input  wire logic fault,
  input  wire logic estop,
  output logic      coil_on
);
  always_latch begin
    if (close_oe_n || (open_line && !open_oe_n) || fault || estop) coil_on <= 1'b0;
    else if (close_line) coil_on <= 1'b1;
  end
endmodule // rlc_latch_model
`default_nettype wire

// File: tb_rlc.sv
// Purpose: Self-checking bench for rlc_host
// Assumes: HOLD_CYC shortened to 10 cycles
// Notes:   Latch model stands in for the relay board
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rlc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        ground_fault_trip = 0, emergency_stop_input = 0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, relay_close_req, relay_close_req_oe_n;
  logic        relay_open_req, relay_open_req_oe_n, irq, coil_on;
  int          miscompares = 0, check_count = 0;
  rlc_host #(.HOLD_CYC(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ground_fault_trip, .emergency_stop_input, .relay_close_req,
    .relay_close_req_oe_n, .relay_open_req, .relay_open_req_oe_n, .irq);
  rlc_latch_model latch (.close_line(relay_close_req), .close_oe_n(relay_close_req_oe_n),
    .open_line(relay_open_req), .open_oe_n(relay_open_req_oe_n), .fault(ground_fault_trip),
    .estop(emergency_stop_input), .coil_on);
  initial forever #4 pclk = ~pclk;
  task automatic results;
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Look between edges so the answer is settled; act on the next edge
    for (n = 0; n < 20; n++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    {rd, err} = {prdata, pslverr};
    @(posedge pclk);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
    if (n == 20) cmp("pready wait", 32'h1, 32'h0);
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 40; n++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 40) begin
      cmp("idle wait", 32'h0, 32'h1);
      results();
    end
  endtask
  task automatic t_close;
    apb(1'b1, OFF_CTRL, 32'h2);
    wait_idle();
    cmp("coil closed", 32'h1, coil_on);
    cmp("flags closed", 32'h1, rd[2:1]);
    cmp("close driven", 32'h0, relay_close_req_oe_n);
    cmp("open driven low", 32'h0, {relay_open_req_oe_n, relay_open_req});
  endtask
  task automatic t_open_irq;
    cmp("irq done", 32'h1, irq);
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    wait_idle();
    cmp("coil opened", 32'h0, coil_on);
    cmp("flags opened", 32'h2, rd[2:1]);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    cmp("masked irq", {31'h0, 1'b1, 1'b0}, {rd[0], irq});
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
  endtask
  task automatic t_trips;
    t_close();
    ground_fault_trip <= 1'b1;
    repeat (4) @(posedge pclk);
    cmp("coil on fault", 32'h0, coil_on);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp("fault pin and closed flag", 32'h2, {rd[5], rd[1]});
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    cmp("fault event", 32'h1, rd[1]);
    ground_fault_trip <= 1'b0;
    t_close();
    emergency_stop_input <= 1'b1;
    repeat (4) @(posedge pclk);
    cmp("coil on stop", 32'h0, coil_on);
    emergency_stop_input <= 1'b0;
    // Let the stop pin leave the synchroniser before any init
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_init_unmapped;
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp("stored stop", 32'h1, rd[3]);
    apb(1'b1, OFF_CTRL, 32'h4);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp("flags after init", 32'h0, rd[3:1]);
    apb(1'b1, 8'h10, 32'h1);
    cmp("unmapped error", 32'h1, err);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    cmp("close undriven", 32'h1, relay_close_req_oe_n);
    cmp("coil at power-up", 32'h0, coil_on);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    t_close();
    t_open_irq();
    t_trips();
    t_init_unmapped();
    results();
  end
endmodule // tb
bind rlc_host rlc_properties #(.HOLD_CYC(HOLD_CYC)) chk (.pclk, .presetn, .pwrite, .paddr, .pwdata,
  .pready, .relay_close_req, .relay_close_req_oe_n, .relay_open_req);
`default_nettype wire
